// *** rtcp_dev_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module rtcp_dev_model (
    // supply side
    input wire logic       core_clk_i,
    input wire logic       supply_i,
    input wire logic       on_level_i,
    // observation
    output var logic [7:0] power_ups_o
);
    logic       on_q  = 1'b0;
    logic [7:0] ups_q = 8'h00;
    assign power_ups_o = ups_q;
    // counts each switch-on of the device supply
    always @(posedge core_clk_i) begin
        on_q <= (supply_i === on_level_i);
        if ((supply_i === on_level_i) && !on_q) begin
            ups_q <= ups_q + 8'h01;
        end
    end
endmodule // rtcp_dev_model
`default_nettype wire

// *** rtcp_map.vh ***
`ifndef RTCP_MAP_VH
`define RTCP_MAP_VH

// register word indices, compared against byte address bits 7:2
`define RTCP_OFS_CTL1       6'h00
`define RTCP_OFS_CTL2       6'h01
`define RTCP_OFS_CTL3       6'h02
`define RTCP_OFS_STAT       6'h03
`define RTCP_OFS_CAP_TIME   6'h04
`define RTCP_OFS_CAP_DATE   6'h05

// first_control_low fields
`define RTCP_TS_EN_BIT      0
`define RTCP_PIN_OUTPUT_SELECT_LSB     4
`define RTCP_PIN_OUTPUT_SELECT_MSB     6
`define RTCP_PIN_OE_BIT     7
`define RTCP_PWC_POL_BIT    9
`define RTCP_PWC_EN_BIT     10
`define RTCP_RTC_EN_BIT     15

// second_control_low fields
`define RTCP_PS_LSB         6
`define RTCP_PS_MSB         7

// third_control_low fields
`define RTCP_STAB_LSB       0
`define RTCP_STAB_MSB       7
`define RTCP_SAMP_LSB       8
`define RTCP_SAMP_MSB       15

// status_low fields
`define RTCP_TS_EVT_BIT     3

// values
`define RTCP_PIN_OUTPUT_SELECT_PWC     3'h3
`define RTCP_WIN_OFF        8'h00
`define RTCP_WIN_ALWAYS     8'hff
`define RTCP_CTL1_RST       16'h0000
`define RTCP_CTL2_RST       16'h0000
`define RTCP_CTL3_RST       16'h0000
`define RTCP_CAP_RST        32'h0000_0000

`endif

// *** rtcp_seq.v ***
`timescale 1ns/1ps
`default_nettype none
`include "rtcp_map.vh"

module rtcp_seq (
    // clock and reset
    input  wire       core_clk_i,
    input  wire       rstn_i,
    // control
    input  wire       run_i,
    input  wire       trigger_i,
    input  wire       tick_i,
    input  wire [7:0] stab_len_i,
    input  wire [7:0] samp_len_i,
    // status and outputs
    output wire       ctl_o,
    output wire       gate_o,
    output wire       stab_o
);

    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_STAB = 3'h2;
    localparam [2:0] ST_SAMP = 3'h4;

    reg  [2:0] st_q;
    reg  [2:0] st_d;
    reg  [7:0] cnt_q;
    reg  [7:0] cnt_d;

    // window ends after len power-control periods, at once when len is zero
    function win_done;
        input [7:0] len;
        input [7:0] cnt;
        input       tick;
        begin
            win_done = (len == `RTCP_WIN_OFF) || (tick && (cnt + 8'h01 == len));
        end
    endfunction

    always @* begin
        st_d  = st_q;
        cnt_d = tick_i ? cnt_q + 8'h01 : cnt_q;
        case (st_q)
            ST_IDLE: begin
                cnt_d = 8'h00;
                if (run_i && trigger_i) begin
                    // see (RL7) (RL24)
                    st_d = (stab_len_i == `RTCP_WIN_OFF) ? ST_SAMP : ST_STAB;
                end
            end
            ST_STAB: begin
                if (stab_len_i != `RTCP_WIN_ALWAYS && win_done(stab_len_i, cnt_q, tick_i)) begin
                    st_d  = ST_SAMP; // see (RL8)
                    cnt_d = 8'h00;
                end
            end
            ST_SAMP: begin
                if (win_done(samp_len_i, cnt_q, tick_i)) begin
                    st_d  = ST_IDLE; // see (RL9)
                end
            end
            default: begin
                st_d  = ST_IDLE;
            end
        endcase
        if (!run_i) begin
            st_d  = ST_IDLE;
        end
    end

    always @(posedge core_clk_i) begin
        if (!rstn_i) begin
            st_q  <= ST_IDLE;
            cnt_q <= 8'h00;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
        end
    end

    assign ctl_o  = st_q[1] | st_q[2];                               // see (RL6)
    assign gate_o = st_q[2] & (samp_len_i != `RTCP_WIN_OFF);         // see (RL13)
    assign stab_o = st_q[1] | (stab_len_i == `RTCP_WIN_ALWAYS);      // see (RL14)

endmodule // rtcp_seq

`default_nettype wire

// *** rtcp_stamp.v ***
`timescale 1ns/1ps
`default_nettype none

module rtcp_stamp (
    // clock and reset
    input  wire core_clk_i,
    input  wire rstn_i,
    // pin and control
    input  wire tamper_i,
    input  wire enable_i,
    input  wire sw_req_i,
    input  wire clr_i,
    // results
    output wire capture_o,
    output wire flag_o,
    output wire irq_o
);

    reg sync1_q;
    reg sync2_q;
    reg sync3_q;
    reg pend_q;
    reg flag_q;
    reg irq_q;

    wire fall;
    wire req;

    assign fall      = sync3_q & ~sync2_q;                             // see (RL25)
    assign req       = ((fall & enable_i) | pend_q) & enable_i;         // see (RL15) (RL16)
    assign capture_o = req & ~flag_q;                                  // see (RL18)

    always @(posedge core_clk_i) begin
        if (!rstn_i) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            sync3_q <= 1'b1;
            pend_q  <= 1'b0;
            flag_q  <= 1'b0;
            irq_q   <= 1'b0;
        end else begin
            sync1_q <= tamper_i;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            // software request waits one cycle, then captures
            pend_q  <= sw_req_i & enable_i & ~flag_q;                  // see (RL20)
            // a capture wins over a clear in the same cycle
            if (capture_o) begin
                flag_q <= 1'b1;                                        // see (RL17) (RL21)
            end else if (clr_i) begin
                flag_q <= 1'b0;
            end
            irq_q   <= capture_o;
        end
    end

    assign flag_o = flag_q;
    assign irq_o  = irq_q;

endmodule // rtcp_stamp

`default_nettype wire

// *** rtcp_top.v ***
// Contract
// (RL1) power sequence runs on the clock unit timebase with no processor help
// (RL2) software enables the clock unit, then sets power_ctl_enable at bit 10
// (RL3) software enables the pin and sets pin_output_select to 011
// (RL4) power_ctl_polarity at bit 9 picks active high or active low
// (RL5) software sets repeat_forever so the sequence repeats; the code has no such bit, a pwc_trigger_i pulse while idle restarts it
// (RL6) running logic drives a power control output and a sample gate
// (RL7) asserting the control output opens the stability window
// (RL8) after the stability window the sample gate opens for the sample window
// (RL9) sample window end closes both windows, drops gate and control
// (RL10) sample length in third_control_low 15:8, stability length in 7:0
// (RL11) each window counts 0 to 255 power-control clock periods
// (RL12) power-control clock is timebase divided by 1, 16, 64 or 256
// (RL13) a window length of zero makes that window inactive
// (RL14) stability length ff keeps the stability window always active
// (RL15) a low pulse on the tamper input triggers a timestamp
// (RL16) tamper capture only while timestamp_enable at bit 0 is set
// (RL17) capture copies time and date, sets status bit 3, raises interrupt
// (RL18) while the event flag is set further capture requests are ignored
// (RL19) with timestamping off capture registers are storage kept over reset
// (RL20) writing 1 to the flag position starts a capture, not setting it
// (RL21) flag sets when a software capture finishes; software polls it
// (RL22) software clears the flag after reading to re-arm capture
// (RL23) captured values are kept as bcd digits like the calendar
// (RL24) with no stability window the sample window starts with control
// (RL25) tamper input passes two flip-flops; capture on its falling edge
//
// The Wishbone interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "rtcp_map.vh"

module rtcp_top (
    // clock and resets
    input  wire        core_clk_i,
    input  wire        rstn_i,
    input  wire        por_rstn_i,
    // wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire        wb_ack_o,
    // clock unit side
    input  wire        timebase_tick_i,
    input  wire        pwc_trigger_i,
    input  wire [31:0] cal_time_i,
    input  wire [31:0] cal_date_i,
    // pins
    input  wire        tamper_i,
    output wire        rtc_pin_o,
    output wire        rtc_pin_oe_o,
    // block outputs
    output wire        power_ctl_o,
    output wire        sample_gate_o,
    output wire        stab_window_o,
    output wire        clock_unit_irq_o
);

    // control and capture registers
    reg  [15:0] ctl1_q;
    reg  [15:0] ctl2_q;
    reg  [15:0] ctl3_q;
    reg  [31:0] cap_time_q;
    reg  [31:0] cap_date_q;
    // bus
    reg         ack_q;
    reg  [31:0] rdat_q;
    reg  [31:0] rdat_d;
    // prescaler
    reg  [7:0]  ps_cnt_q;

    wire        req;
    wire        wr;
    wire [5:0]  idx;
    wire [31:0] wmask;
    wire        ts_en;
    wire        run;
    wire        pwc_tick;
    wire [1:0]  ps_sel;
    wire [7:0]  stab_len;
    wire [7:0]  samp_len;
    wire        seq_ctl;
    wire        seq_gate;
    wire        seq_stab;
    wire        cap;
    wire        ts_flag;
    wire        ts_irq;
    wire        stat_wr;
    wire        sw_req;
    wire        clr;

    // byte enables to bit mask
    function [31:0] sel_mask;
        input [3:0] sel;
        begin
            sel_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        end
    endfunction

    // true when a write hits register index r
    function hit;
        input [5:0] a;
        input [5:0] r;
        input       w;
        begin
            hit = w && (a == r);
        end
    endfunction

    // terminal count mask of the power-control prescaler
    function [7:0] ps_mask;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    ps_mask = 8'h00;
                2'h1:    ps_mask = 8'h0f;
                2'h2:    ps_mask = 8'h3f;
                default: ps_mask = 8'hff;
            endcase
        end
    endfunction

    // bus decode
    assign req   = wb_cyc_i & wb_stb_i;
    assign wr    = req & wb_we_i & ack_q;
    assign idx   = wb_adr_i[7:2];
    assign wmask = sel_mask(wb_sel_i);

    // field taps
    assign ts_en    = ctl1_q[`RTCP_TS_EN_BIT];
    assign ps_sel   = ctl2_q[`RTCP_PS_MSB:`RTCP_PS_LSB];
    assign stab_len = ctl3_q[`RTCP_STAB_MSB:`RTCP_STAB_LSB];             // see (RL10) (RL11)
    assign samp_len = ctl3_q[`RTCP_SAMP_MSB:`RTCP_SAMP_LSB];             // see (RL10) (RL11)

    // sequencer runs from the timebase alone when both enables are set
    assign run = ctl1_q[`RTCP_RTC_EN_BIT] & ctl1_q[`RTCP_PWC_EN_BIT];    // see (RL1)

    // status write effects
    assign stat_wr = hit(idx, `RTCP_OFS_STAT, wr) & wb_sel_i[0];
    assign sw_req  = stat_wr & wb_dat_i[`RTCP_TS_EVT_BIT];               // see (RL20)
    assign clr     = stat_wr & ~wb_dat_i[`RTCP_TS_EVT_BIT];

    // wishbone ack, one wait state, dropped after one cycle
    always @(posedge core_clk_i) begin
        if (!rstn_i) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q  <= req & ~ack_q;
            rdat_q <= rdat_d;
        end
    end

    // read mux, unmapped reads give zero
    always @* begin
        rdat_d = 32'h0000_0000;
        case (idx)
            `RTCP_OFS_CTL1:     rdat_d = {16'h0000, ctl1_q};
            `RTCP_OFS_CTL2:     rdat_d = {16'h0000, ctl2_q};
            `RTCP_OFS_CTL3:     rdat_d = {16'h0000, ctl3_q};
            `RTCP_OFS_STAT:     rdat_d = {28'h0000000, ts_flag, 3'h0};
            `RTCP_OFS_CAP_TIME: rdat_d = cap_time_q;
            `RTCP_OFS_CAP_DATE: rdat_d = cap_date_q;
            default:            rdat_d = 32'h0000_0000;
        endcase
    end

    // control registers on the ordinary reset
    always @(posedge core_clk_i) begin
        if (!rstn_i) begin
            ctl1_q <= `RTCP_CTL1_RST;
            ctl2_q <= `RTCP_CTL2_RST;
            ctl3_q <= `RTCP_CTL3_RST;
        end else begin
            if (hit(idx, `RTCP_OFS_CTL1, wr)) begin
                ctl1_q <= (ctl1_q & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]); // see (RL4)
            end
            if (hit(idx, `RTCP_OFS_CTL2, wr)) begin
                ctl2_q <= (ctl2_q & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]); // see (RL12)
            end
            if (hit(idx, `RTCP_OFS_CTL3, wr)) begin
                ctl3_q <= (ctl3_q & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]); // see (RL10)
            end
        end
    end

    // capture registers clear only on power-on reset
    always @(posedge core_clk_i) begin
        if (!por_rstn_i) begin
            cap_time_q <= `RTCP_CAP_RST;
            cap_date_q <= `RTCP_CAP_RST;
        end else if (cap) begin
            cap_time_q <= cal_time_i;                                   // see (RL17) (RL23)
            cap_date_q <= cal_date_i;                                   // see (RL17) (RL23)
        end else if (!ts_en) begin
            if (hit(idx, `RTCP_OFS_CAP_TIME, wr)) begin
                cap_time_q <= (cap_time_q & ~wmask) | (wb_dat_i & wmask); // see (RL19)
            end
            if (hit(idx, `RTCP_OFS_CAP_DATE, wr)) begin
                cap_date_q <= (cap_date_q & ~wmask) | (wb_dat_i & wmask); // see (RL19)
            end
        end
    end

    // power-control clock prescaler on timebase ticks
    always @(posedge core_clk_i) begin
        if (!rstn_i) begin
            ps_cnt_q <= 8'h00;
        end else if (!run) begin
            ps_cnt_q <= 8'h00;
        end else if (timebase_tick_i) begin
            if ((ps_cnt_q & ps_mask(ps_sel)) == ps_mask(ps_sel)) begin
                ps_cnt_q <= 8'h00;
            end else begin
                ps_cnt_q <= ps_cnt_q + 8'h01;
            end
        end
    end

    assign pwc_tick = timebase_tick_i & ((ps_cnt_q & ps_mask(ps_sel)) == ps_mask(ps_sel)); // see (RL12)

    rtcp_seq u_seq (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .run_i      (run),
        .trigger_i  (pwc_trigger_i),
        .tick_i     (pwc_tick),
        .stab_len_i (stab_len),
        .samp_len_i (samp_len),
        .ctl_o      (seq_ctl),
        .gate_o     (seq_gate),
        .stab_o     (seq_stab)
    );

    rtcp_stamp u_stamp (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .tamper_i   (tamper_i),
        .enable_i   (ts_en),
        .sw_req_i   (sw_req),
        .clr_i      (clr),
        .capture_o  (cap),
        .flag_o     (ts_flag),
        .irq_o      (ts_irq)
    );

    // outputs
    assign wb_dat_o         = ack_q ? rdat_q : 32'h0000_0000;
    assign wb_ack_o         = ack_q;
    assign power_ctl_o      = seq_ctl ? ctl1_q[`RTCP_PWC_POL_BIT] : ~ctl1_q[`RTCP_PWC_POL_BIT]; // see (RL4)
    assign sample_gate_o    = seq_gate;                                   // see (RL6)
    assign stab_window_o    = seq_stab;
    assign clock_unit_irq_o = ts_irq;                                     // see (RL17)
    assign rtc_pin_oe_o     = ctl1_q[`RTCP_PIN_OE_BIT];
    assign rtc_pin_o        = (ctl1_q[`RTCP_PIN_OUTPUT_SELECT_MSB:`RTCP_PIN_OUTPUT_SELECT_LSB] == `RTCP_PIN_OUTPUT_SELECT_PWC)
                              & power_ctl_o;

endmodule // rtcp_top

`default_nettype wire

// *** rtcp_top_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module rtcp_chk (
    // clock and reset
    input wire logic        core_clk_i,
    input wire logic        rstn_i,
    // bus and inputs
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        timebase_tick_i,
    input wire logic        pwc_trigger_i,
    input wire logic        tamper_i,
    // outputs
    input wire logic        rtc_pin_oe_o,
    input wire logic        power_ctl_o,
    input wire logic        sample_gate_o,
    input wire logic        stab_window_o,
    input wire logic        clock_unit_irq_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered next cycle");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    a_gate_stab_excl: assert property (sample_gate_o |-> !stab_window_o)
        else $error("gate open inside stability window");
    a_gate_cause: assert property ($rose(sample_gate_o) |->
        $past(timebase_tick_i) || $past(pwc_trigger_i))
        else $error("gate opened without tick or trigger");
    a_gate_end_ctl: assert property ($fell(sample_gate_o) |-> $changed(power_ctl_o))
        else $error("control not dropped with gate");
    a_stab_end: assert property ($fell(stab_window_o) |->
        $past(timebase_tick_i) || $past(wb_ack_o))
        else $error("stability window closed without tick");
    a_irq_pulse: assert property (clock_unit_irq_o |=> !clock_unit_irq_o)
        else $error("irq longer than one cycle");
    a_irq_cause: assert property (clock_unit_irq_o |-> !$past(tamper_i, 3) ||
        $past(wb_ack_o, 2) || $past(wb_ack_o, 3) || $past(wb_ack_o, 4))
        else $error("irq without capture request");
    a_oe_write: assert property ($changed(rtc_pin_oe_o) |->
        $past(wb_ack_o) || !$past(rstn_i))
        else $error("pin enable changed without write");
    c_gate: cover property ($rose(sample_gate_o));
    c_stab: cover property ($fell(stab_window_o));
    c_irq: cover property (clock_unit_irq_o);
endmodule // rtcp_chk

bind rtcp_top rtcp_chk u_rtcp_chk (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timebase_tick_i(timebase_tick_i),
    .pwc_trigger_i(pwc_trigger_i), .tamper_i(tamper_i), .rtc_pin_oe_o(rtc_pin_oe_o),
    .power_ctl_o(power_ctl_o), .sample_gate_o(sample_gate_o),
    .stab_window_o(stab_window_o), .clock_unit_irq_o(clock_unit_irq_o));
`default_nettype wire

// *** rtcp_top_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module rtcp_top_tb_top;
    logic        clk = 0;
    logic        rst_n = 0;
    logic        por_n = 0;
    logic        cyc = 0;
    logic        stb = 0;
    logic        we = 0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic        tick = 0;
    logic [3:0]  sel = 4'h0;
    logic        trig = 0;
    logic [31:0] ctime = 32'h00123456;
    logic [31:0] cdate = 32'h00250314;
    logic        tamper = 1;
    logic [31:0] r;
    wire  [31:0] rdat;
    wire         ack, pin, pin_oe, pwr, gate, stab, irq;
    wire  [7:0]  ups;
    int          n_errors = 0;
    int          total_checks = 0;
    int          i, ps, n, dv;
    always #2.5 clk = ~clk;
    // timebase tick on every other clock cycle
    always @(posedge clk) tick <= ~tick;
    rtcp_top u_rtcp_top (.core_clk_i(clk), .rstn_i(rst_n), .por_rstn_i(por_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .timebase_tick_i(tick),
        .pwc_trigger_i(trig), .cal_time_i(ctime), .cal_date_i(cdate), .tamper_i(tamper),
        .rtc_pin_o(pin), .rtc_pin_oe_o(pin_oe), .power_ctl_o(pwr), .sample_gate_o(gate),
        .stab_window_o(stab), .clock_unit_irq_o(irq));
    rtcp_dev_model u_rtcp_dev_model (.core_clk_i(clk), .supply_i(pin), .on_level_i(1'b1),
        .power_ups_o(ups));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int k;
        k = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        @(posedge clk);
        while (ack !== 1'b1) begin
            k++;
            if (k > 20) begin
                chk(32'h0, 32'h1);
                stop_test();
            end
            @(posedge clk);
        end
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hf);
        chk(r, e);
    endtask
    task automatic wrb(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        bus(1'b1, a, d, s);
    endtask
    task automatic pulse;
        @(posedge clk);
        trig <= 1'b1;
        @(posedge clk);
        trig <= 1'b0;
    endtask
    task automatic wait_gate(input logic v);
        n = 0;
        while (gate !== v) begin
            @(posedge clk);
            n++;
            if (n > 2000) begin
                chk(32'h0, 32'h1);
                stop_test();
            end
        end
    endtask
    task automatic tamp(input logic [31:0] exp);
        logic [31:0] seen;
        seen = 32'h0;
        @(posedge clk);
        tamper <= 1'b0;
        repeat (12) begin
            @(posedge clk);
            seen = seen + irq;
        end
        tamper <= 1'b1;
        chk(seen, exp);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        rd(8'h00, 32'h0);
        chk(pwr, 1'b1);
        wr(8'h00, 32'h000086b0);
        rd(8'h00, 32'h000086b0);
        rd(8'h40, 32'h0);
        @(negedge clk);
        chk(pwr, 1'b0);
        chk(pin, pwr);
        chk(pin_oe, 1'b1);
        wr(8'h08, 32'h00000302);
        for (ps = 0; ps < 4; ps++) begin
            dv = (ps == 0) ? 1 : (1 << (2 * ps + 2));
            wr(8'h04, ps << 6);
            pulse();
            @(negedge clk);
            chk({pwr, stab, gate}, 3'b110);
            wait_gate(1'b1);
            chk(n >= 2 * dv + 2 && n <= 4 * dv + 1, 1'b1);
            wait_gate(1'b0);
            chk(n, 6 * dv);
            @(negedge clk);
            chk(pwr, 1'b0);
        end
        chk(ups, 8'h04);
        wr(8'h04, 32'h0);
        wr(8'h08, 32'h00000300);
        pulse();
        @(negedge clk);
        chk({pwr, gate}, 2'b11);
        wait_gate(1'b0);
        wr(8'h08, 32'h00000002);
        pulse();
        for (i = 0; i < 8; i++) begin
            @(negedge clk);
            chk(gate, 1'b0);
        end
        chk(pwr, 1'b0);
        wr(8'h00, 32'h000082b0);
        wr(8'h08, 32'h000000ff);
        @(negedge clk);
        chk(stab, 1'b1);
        wrb(8'h08, 32'h00001111, 4'h2);
        rd(8'h08, 32'h000011ff);
        wr(8'h08, 32'h0);
        $display("test power sequence done");
        wr(8'h00, 32'h000082b1);
        tamp(1);
        rd(8'h0c, 32'h8);
        rd(8'h10, ctime);
        rd(8'h14, cdate);
        ctime <= 32'h00235959;
        tamp(0);
        wr(8'h0c, 32'h8);
        rd(8'h10, 32'h00123456);
        wrb(8'h0c, 32'h0, 4'he);
        rd(8'h0c, 32'h8);
        wr(8'h0c, 32'h0);
        rd(8'h0c, 32'h0);
        wr(8'h0c, 32'h8);
        repeat (4) @(posedge clk);
        rd(8'h0c, 32'h8);
        rd(8'h10, 32'h00235959);
        wr(8'h0c, 32'h0);
        wr(8'h00, 32'h000082b0);
        tamp(0);
        wr(8'h0c, 32'h8);
        rd(8'h0c, 32'h0);
        wr(8'h10, 32'h0000a5a5);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h10, 32'h0000a5a5);
        rd(8'h00, 32'h0);
        por_n <= 1'b0;
        repeat (2) @(posedge clk);
        por_n <= 1'b1;
        rd(8'h10, 32'h0);
        $display("test timestamp done");
        stop_test();
    end
endmodule // rtcp_top_tb_top
`default_nettype wire
